// ==== hw/lcd_host_port.sv ====
// Parallel host bus port of a bit-map LCD driver with an AXI4-Lite control slave
`timescale 1ns/100ps
`default_nettype none
`include "lcd_port_defs.svh"
module lcd_host_port (
   input wire logic clk_sys, // System clock, 125 MHz
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic select_n, // Device select pin, high ignores every access except the reset command
   input wire logic register_select, // 1 display data, 0 status or command
   input wire logic dir_or_write_n, // 68 style read/write, 80 style write strobe low
   input wire logic strobe_or_read_n, // 68 style enable high, 80 style read strobe low
   input wire logic reset_level, // Level of the reset pin, sampled at reset command
   input wire logic [7:0] data_in, // Data lines as seen at the pins
   output logic [7:0] data_out, // Data driven onto the lines
   output logic data_oe, // High while the port drives the data lines
   input wire logic [3:0] s_axi_awaddr, // AXI write address
   input wire logic s_axi_awvalid, // AXI write address valid
   output logic s_axi_awready, // AXI write address ready
   input wire logic [31:0] s_axi_wdata, // AXI write data
   input wire logic [3:0] s_axi_wstrb, // AXI write strobes
   input wire logic s_axi_wvalid, // AXI write data valid
   output logic s_axi_wready, // AXI write data ready
   output logic [1:0] s_axi_bresp, // AXI write response
   output logic s_axi_bvalid, // AXI write response valid
   input wire logic s_axi_bready, // AXI write response ready
   input wire logic [3:0] s_axi_araddr, // AXI read address
   input wire logic s_axi_arvalid, // AXI read address valid
   output logic s_axi_arready, // AXI read address ready
   output logic [31:0] s_axi_rdata, // AXI read data
   output logic [1:0] s_axi_rresp, // AXI read response
   output logic s_axi_rvalid, // AXI read data valid
   input wire logic s_axi_rready // AXI read data ready
);
   // Pin synchronisers: first stage feeds only the second
   logic [12:0] sync_a_q, sync_b_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync_a_q <= `SYNC_IDLE;
         sync_b_q <= `SYNC_IDLE;
      end else begin
         sync_a_q <= {select_n, register_select, dir_or_write_n, strobe_or_read_n, reset_level, data_in};
         sync_b_q <= sync_a_q;
      end
   end
   wire pin_sel_n = sync_b_q[12];
   wire pin_rs = sync_b_q[11];
   wire pin_dir = sync_b_q[10];
   wire pin_strb = sync_b_q[9];
   wire pin_level = sync_b_q[8];
   wire [7:0] pin_data = sync_b_q[7:0];
   logic style68_q, strobe_prev_q;
   lcd_port_pkg::access_state_t state_q;
   logic acc_rs_q, acc_read_q, acc_sel_q;
   logic [7:0] wbyte_q, holder_q, wpend_q;
   logic [`RAM_AW-1:0] pend_addr_q;
   logic [`COL_W-1:0] col_q, saved_col_q;
   logic [`PAGE_W-1:0] page_q;
   logic [`LINE_W-1:0] line_q;
   logic rmw_q, adc_q, disp_off_q, static_q, duty_q, pend_q;
   logic ctrl_busy_q, ctrl_init_q;
   wire strobe_act = style68_q ? pin_strb : (~pin_strb | ~pin_dir);
   wire dir_read = style68_q ? pin_dir : ~pin_strb;
   wire lead = strobe_act & ~strobe_prev_q;
   wire trail = ~strobe_act & strobe_prev_q & (state_q == lcd_port_pkg::ST_ACCESS);
   // access decode from latched select and direction
   wire data_rd = trail & acc_sel_q & acc_rs_q & acc_read_q;
   wire data_wr = trail & acc_sel_q & acc_rs_q & ~acc_read_q;
   wire cmd_any = trail & ~acc_rs_q & ~acc_read_q;
   // reset command is taken even while deselected
   wire cmd_reset = cmd_any & (wbyte_q == `CMD_RESET);
   wire cmd_wr = cmd_any & acc_sel_q;
   wire is_col = wbyte_q[7] == `CMD_COL_TOP;
   wire is_onoff = wbyte_q[7:1] == `CMD_ONOFF_TOP;
   wire is_line = wbyte_q[7:5] == `CMD_LINE_TOP;
   wire is_page = wbyte_q[7:2] == `CMD_PAGE_TOP;
   wire is_adc = wbyte_q[7:1] == `CMD_ADC_TOP;
   wire is_static = wbyte_q[7:1] == `CMD_STATIC_TOP;
   wire is_duty = wbyte_q[7:1] == `CMD_DUTY_TOP;
   wire is_rmw = wbyte_q == `CMD_RMW;
   wire is_end = wbyte_q == `CMD_END;
   wire [7:0] status_byte = {ctrl_busy_q, adc_q, disp_off_q, ctrl_init_q, 4'h0};
   // column stops at its limit, page untouched
   wire [`COL_W-1:0] col_inc = (col_q == `COL_STOP) ? col_q : col_q + 7'h01;
   // reads leave the column alone in read-modify-write
   wire col_step = data_wr | (data_rd & ~rmw_q);
   wire [`RAM_AW-1:0] cur_addr = {page_q, col_q};
   // commit previous held byte on this write
   wire ram_we = data_wr & pend_q;
   wire [7:0] ram_rdata;
   display_ram u_ram (
      .clk_sys(clk_sys),
      .we(ram_we),
      .waddr(pend_addr_q),
      .wdata(wpend_q),
      .raddr(cur_addr),
      .rdata(ram_rdata)
   );
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= lcd_port_pkg::ST_IDLE;
         strobe_prev_q <= 1'b0;
         acc_rs_q <= 1'b0;
         acc_read_q <= 1'b0;
         acc_sel_q <= 1'b0;
         wbyte_q <= 8'h00;
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end else begin
         strobe_prev_q <= strobe_act;
         if (strobe_act) begin
            wbyte_q <= pin_data;
         end
         case (state_q)
            lcd_port_pkg::ST_IDLE: begin
               if (lead) begin
                  state_q <= lcd_port_pkg::ST_ACCESS;
                  acc_rs_q <= pin_rs;
                  acc_read_q <= dir_read;
                  acc_sel_q <= ~pin_sel_n;
                  // data read answered from the holder at once, status read from the status byte
                  data_out <= pin_rs ? holder_q : status_byte;
                  // drive the data lines on selected reads
                  data_oe <= dir_read & ~pin_sel_n;
               end
            end
            lcd_port_pkg::ST_ACCESS: begin
               if (!strobe_act) begin
                  data_oe <= 1'b0;
                  state_q <= data_rd ? lcd_port_pkg::ST_FETCH : lcd_port_pkg::ST_IDLE;
               end
            end
            lcd_port_pkg::ST_FETCH: begin
               state_q <= lcd_port_pkg::ST_IDLE;
            end
            default: begin
               state_q <= lcd_port_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // Holder, address counters and display modes
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         holder_q <= 8'h00;
         wpend_q <= 8'h00;
         pend_q <= 1'b0;
         pend_addr_q <= '0;
         col_q <= '0;
         saved_col_q <= '0;
         page_q <= `PAGE_RESET;
         line_q <= `LINE_RESET;
         rmw_q <= 1'b0;
         adc_q <= 1'b0;
         disp_off_q <= 1'b1;
         static_q <= 1'b0;
         duty_q <= 1'b0;
         style68_q <= 1'b1;
      end else begin
         // holder refills from RAM after each data read
         if (state_q == lcd_port_pkg::ST_FETCH) begin
            holder_q <= ram_rdata;
         end
         // new write byte waits in the holder
         if (data_wr) begin
            holder_q <= wbyte_q;
            wpend_q <= wbyte_q;
            pend_addr_q <= cur_addr;
            pend_q <= 1'b1;
         end
         if (col_step) begin
            col_q <= col_inc;
         end
         if (cmd_reset) begin
            // bus style taken from the reset pin
            style68_q <= pin_level;
            line_q <= `LINE_RESET;
            page_q <= `PAGE_RESET;
         end else if (cmd_wr) begin
            if (is_col && !rmw_q) begin
               col_q <= wbyte_q[`COL_W-1:0];
            end
            if (is_onoff) begin
               disp_off_q <= wbyte_q[0];
            end
            if (is_line) begin
               line_q <= wbyte_q[`LINE_W-1:0];
            end
            if (is_page) begin
               page_q <= wbyte_q[`PAGE_W-1:0];
            end
            if (is_adc) begin
               adc_q <= wbyte_q[0];
            end
            if (is_static) begin
               static_q <= wbyte_q[0];
            end
            if (is_duty) begin
               duty_q <= wbyte_q[0];
            end
            // save column on entry, restore at end
            if (is_rmw) begin
               rmw_q <= 1'b1;
               saved_col_q <= col_q;
            end
            if (is_end && rmw_q) begin
               rmw_q <= 1'b0;
               col_q <= saved_col_q;
            end
         end
      end
   end
   // AXI4-Lite slave
   logic aw_full_q, w_full_q;
   logic [3:0] awaddr_q, wstrb_q;
   logic [31:0] wdata_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire aw_full_d = aw_take | (aw_full_q & ~do_write);
   wire w_full_d = w_take | (w_full_q & ~do_write);
   wire wr_ctrl = do_write & (awaddr_q == `REG_CTRL);
   wire wr_known = (awaddr_q == `REG_CTRL) | (awaddr_q == `REG_STATUS) | (awaddr_q == `REG_ADDR);
   wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire rd_ctrl = s_axi_araddr == `REG_CTRL;
   wire rd_status = s_axi_araddr == `REG_STATUS;
   wire rd_addr = s_axi_araddr == `REG_ADDR;
   wire [31:0] reg_ctrl = {30'h0000_0000, ctrl_init_q, ctrl_busy_q};
   wire [31:0] reg_status = {19'h0_0000, pend_q, duty_q, static_q, rmw_q, style68_q, status_byte};
   wire [31:0] reg_addr = {11'h000, line_q, 6'h00, page_q, 1'b0, col_q};
   wire [31:0] rd_mux = rd_ctrl ? reg_ctrl : rd_status ? reg_status : rd_addr ? reg_addr : 32'h0000_0000;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_OKAY;
         ctrl_busy_q <= 1'b0;
         ctrl_init_q <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         s_axi_awready <= ~aw_full_d;
         s_axi_wready <= ~w_full_d;
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid <= rvalid_d;
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // software drives busy and init shown in status
         if (wr_ctrl && wstrb_q[0]) begin
            ctrl_busy_q <= wdata_q[`CTRL_BUSY];
            ctrl_init_q <= wdata_q[`CTRL_INIT];
         end
         if (ar_take) begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (rd_ctrl | rd_status | rd_addr) ? `AXI_OKAY : `AXI_SLVERR;
         end
      end
   end
endmodule : lcd_host_port
`default_nettype wire

// ==== hw/lcd_port_defs.svh ====
// Constants for the LCD host bus port: pin codes, command codes, register map
`ifndef LCD_PORT_DEFS_SVH
`define LCD_PORT_DEFS_SVH

`define COL_W 7
`define PAGE_W 2
`define LINE_W 5
`define RAM_AW 9
`define COL_STOP 7'h50
`define PAGE_RESET 2'h3
`define LINE_RESET 5'h00
// Synchroniser reset holds the idle pin levels of the 68 style, so no false strobe edge follows reset
`define SYNC_IDLE 13'h1dff

// Command codes, compared on the upper bits only, except RMW, END and RESET on the whole byte
`define CMD_COL_TOP 1'h0
`define CMD_ONOFF_TOP 7'h57
`define CMD_LINE_TOP 3'h6
`define CMD_PAGE_TOP 6'h2e
`define CMD_ADC_TOP 7'h50
`define CMD_STATIC_TOP 7'h52
`define CMD_DUTY_TOP 7'h54
`define CMD_RMW 8'he0
`define CMD_END 8'hee
`define CMD_RESET 8'he2

// Register map (byte addresses)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ADDR 4'h8
`define CTRL_BUSY 0
`define CTRL_INIT 1
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ==== hw/lcd_port_pkg.sv ====
// Types shared by the LCD host bus port
`default_nettype none
package lcd_port_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACCESS = 3'b010,
      ST_FETCH = 3'b100
   } access_state_t;
endpackage : lcd_port_pkg
`default_nettype wire

// ==== hw/display_ram.sv ====
// Display data RAM with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "lcd_port_defs.svh"
module display_ram (
   input wire logic clk_sys, // System clock
   input wire logic we, // Write enable
   input wire logic [`RAM_AW-1:0] waddr, // Write address {page,column}
   input wire logic [7:0] wdata, // Write byte
   input wire logic [`RAM_AW-1:0] raddr, // Read address {page,column}
   output logic [7:0] rdata // Read byte, one cycle after raddr
);
   logic [7:0] mem [0:(1<<`RAM_AW)-1];
   // Contents are not reset: display data survive the port's reset
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : display_ram
`default_nettype wire

// ==== testbench/lcd_host_port_chk.sv ====
// Concurrent checks on the ports of the LCD host bus port
`timescale 1ns/100ps
`default_nettype none
module lcd_host_port_chk (
   input wire logic clk_sys, // Clock
   input wire logic reset_n, // Reset, active low
   input wire logic select_n, // Device select
   input wire logic dir_or_write_n, // Direction or write strobe
   input wire logic data_oe, // Line drive
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready // R ready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // Six cycles cover the pin synchroniser and the output register
   desel_quiet_a: assert property (select_n [*6] |-> !data_oe)
      else $error("data lines driven while deselected");
   oe_after_sel_a: assert property ($rose(data_oe) |-> !$past(select_n, 3))
      else $error("data lines driven without a select");
   write_quiet_a: assert property (!dir_or_write_n [*5] |-> !data_oe)
      else $error("data lines driven during a write");
   oe_holds_a: assert property ($rose(data_oe) |=> data_oe [*3])
      else $error("read byte withdrawn too early");
   wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##[0:1] s_axi_awready && s_axi_wready)
      else $error("write channel not freed");
   rd_resp_a: assert property (ar_taken |-> ##[1:2] (s_axi_rvalid && !s_axi_arready))
      else $error("read response missing");
   ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not retired");
endmodule : lcd_host_port_chk
bind lcd_host_port lcd_host_port_chk i_chk (
   .clk_sys, .reset_n, .select_n, .dir_or_write_n, .data_oe, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ==== testbench/mpu_host_model.sv ====
// Behavioural model of the host processor on the parallel pins
`timescale 1ns/100ps
`default_nettype none
module mpu_host_model (
   input wire logic clk_sys, // Clock
   output logic select_n, // Device select
   output logic register_select, // Data or command
   output logic dir_or_write_n, // Direction or write strobe
   output logic strobe_or_read_n, // Enable or read strobe
   output logic [7:0] data_in, // Lines seen by the port
   input wire logic [7:0] data_out, // Port drive
   input wire logic data_oe // Port drives lines
);
   logic style68 = 1'b1;
   logic drv = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] last_q = 8'h00;
   initial begin
      select_n = 1'b1;
      register_select = 1'b0;
      dir_or_write_n = 1'b1;
      strobe_or_read_n = 1'b0;
   end
   // released lines toggle so a stale byte never passes as read data
   always_comb data_in = drv ? wd : (data_oe ? data_out : ~last_q);
   always @(posedge clk_sys) last_q <= data_in;
   task automatic set_style(input logic v);
      @(posedge clk_sys);
      style68 <= v;
      strobe_or_read_n <= !v;
   endtask : set_style
   task automatic access(input logic sel_n, input logic rs, input logic rd, input logic [7:0] wbyte,
                         output logic [7:0] rbyte);
      @(posedge clk_sys);
      select_n <= sel_n;
      register_select <= rs;
      dir_or_write_n <= style68 ? rd : 1'b1;
      wd <= wbyte;
      drv <= !rd;
      repeat (3) @(posedge clk_sys);
      // strobe polarity follows the bus style
      if (style68) strobe_or_read_n <= 1'b1;
      else if (rd) strobe_or_read_n <= 1'b0;
      else dir_or_write_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rbyte = data_in;
      strobe_or_read_n <= !style68;
      dir_or_write_n <= style68 ? rd : 1'b1;
      repeat (3) @(posedge clk_sys);
      drv <= 1'b0;
      select_n <= 1'b1;
      dir_or_write_n <= 1'b1;
      // idle gap keeps the cycle time
      repeat (8) @(posedge clk_sys);
   endtask : access
endmodule : mpu_host_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking testbench for the LCD host bus port
`timescale 1ns/100ps
`default_nettype none
`include "lcd_port_defs.svh"
module testbench;
   typedef struct packed {
      logic [1:0] kind;
      logic desel;
      logic rs;
      logic [3:0] addr;
      logic [7:0] data;
      logic [31:0] exp;
   } row_t;
   // Kind 0 pin write, 1 pin read, 2 register write, 3 register read
   row_t rows [32] = '{
      48'h0000_0000_0000, 48'h10A5_0000_0000, 48'h103C_0000_0000, 48'h1011_0000_0000, 48'h0000_0000_0000,
      48'h5000_0000_0011, 48'h5000_0000_00A5, 48'h5000_0000_003C, 48'hC800_0000_0303, 48'h4000_0000_0020,
      48'h00AE_0000_0000, 48'h00A1_0000_0000, 48'h4000_0000_0040, 48'h8003_0000_0000, 48'h4000_0000_00D0,
      48'h8000_0000_0000, 48'h004F_0000_0000, 48'h1077_0000_0000, 48'h1078_0000_0000, 48'h00B8_0000_0000,
      48'hC800_0000_0050, 48'h2010_0000_0000, 48'hC800_0000_0050, 48'h00C5_0000_0000, 48'h0005_0000_0000,
      48'h00E0_0000_0000, 48'h5000_0000_0078, 48'h1099_0000_0000, 48'h00EE_0000_0000, 48'hC800_0005_0005,
      48'h8C00_0000_0002, 48'hCC00_0000_0000};
   logic clk_sys, reset_n, select_n, register_select, dir_or_write_n, strobe_or_read_n, reset_level;
   logic data_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] data_in, data_out, rb;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int error_cnt = 0;
   int tests_run = 0;
   lcd_host_port i_lcd_host_port (
      .clk_sys, .reset_n, .select_n, .register_select, .dir_or_write_n, .strobe_or_read_n, .reset_level,
      .data_in, .data_out, .data_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   mpu_host_model i_mpu_host_model (
      .clk_sys, .select_n, .register_select, .dir_or_write_n, .strobe_or_read_n, .data_in, .data_out, .data_oe
   );
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic finish_test();
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Each channel is taken at the rising edge where its valid and ready are both high
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic h;
      int n;
      h = 1'b0;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!h && n < 200) begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            h = 1'b1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      if (!h) begin
         error_cnt++;
         finish_test();
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic h;
      int n;
      h = 1'b0;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!h && n < 200) begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            h = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      if (!h) begin
         error_cnt++;
         finish_test();
      end
   endtask : axi_rd
   initial begin
      reset_n = 1'b0;
      reset_level = 1'b1;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wdata = 32'h0000_0000;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      foreach (rows[i]) begin
         case (rows[i].kind)
            2'd0: i_mpu_host_model.access(rows[i].desel, rows[i].rs, 1'b0, rows[i].data, rb);
            2'd1: begin
               i_mpu_host_model.access(rows[i].desel, rows[i].rs, 1'b1, 8'h00, rb);
               check("pin read", {24'h00_0000, rb}, rows[i].exp);
            end
            2'd2: begin
               axi_wr(rows[i].addr, {24'h00_0000, rows[i].data}, rr);
               check("write resp", {30'h0000_0000, rr}, rows[i].exp);
            end
            default: begin
               axi_rd(rows[i].addr, rd, rr);
               check("reg read", rd, rows[i].exp);
               check("read resp", {30'h0000_0000, rr},
                     {30'h0000_0000, (rows[i].addr == 4'hC) ? `AXI_SLVERR : `AXI_OKAY});
            end
         endcase
      end
      // Reset command while deselected, with the pin low
      reset_level <= 1'b0;
      i_mpu_host_model.access(1'b1, 1'b0, 1'b0, 8'hE2, rb);
      i_mpu_host_model.set_style(1'b0);
      axi_rd(4'h4, rd, rr);
      check("style", rd & 32'h0000_01FF, 32'h0000_0040);
      axi_rd(4'h8, rd, rr);
      check("addr", rd, 32'h0000_0305);
      i_mpu_host_model.access(1'b0, 1'b0, 1'b0, 8'h00, rb);
      i_mpu_host_model.access(1'b0, 1'b1, 1'b1, 8'h00, rb);
      check("dummy read", {24'h00_0000, rb}, 32'h0000_0099);
      i_mpu_host_model.access(1'b0, 1'b1, 1'b1, 8'h00, rb);
      check("data read", {24'h00_0000, rb}, 32'h0000_00A5);
      // Static drive and duty commands, with a write still pending
      i_mpu_host_model.access(1'b0, 1'b0, 1'b0, 8'hA5, rb);
      i_mpu_host_model.access(1'b0, 1'b0, 1'b0, 8'hA9, rb);
      axi_rd(4'h4, rd, rr);
      check("modes", rd & 32'h0000_1E00, 32'h0000_1C00);
      // Idle levels of the default style first, or the enable looks active
      i_mpu_host_model.set_style(1'b1);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      axi_rd(4'h8, rd, rr);
      check("addr reset", rd, 32'h0000_0300);
      axi_rd(4'h4, rd, rr);
      check("status reset", rd & 32'h0000_1FFF, 32'h0000_0120);
      finish_test();
   end
endmodule : testbench
`default_nettype wire
